// file: common/fpd_cfg.svh
// constants of the function code decoder: codes, sub-codes, exception values
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH
`define FPD_FC_RD_COILS 8'h01
`define FPD_FC_RD_DISC 8'h02
`define FPD_FC_RD_HOLD 8'h03
`define FPD_FC_RD_INREG 8'h04
`define FPD_FC_WR_COIL 8'h05
`define FPD_FC_WR_REG 8'h06
`define FPD_FC_RD_EXCST 8'h07
`define FPD_FC_DIAG 8'h08
`define FPD_FC_EVT_CNT 8'h0B
`define FPD_FC_EVT_LOG 8'h0C
`define FPD_FC_WR_COILS 8'h0F
`define FPD_FC_WR_REGS 8'h10
`define FPD_FC_SRV_ID 8'h11
`define FPD_FC_RD_FILE 8'h14
`define FPD_FC_WR_FILE 8'h15
`define FPD_FC_MASK_WR 8'h16
`define FPD_FC_RW_REGS 8'h17
`define FPD_FC_RD_QUEUE 8'h18
`define FPD_FC_ENCAP 8'h2B
`define FPD_USER_LO_A 8'h41
`define FPD_USER_HI_A 8'h48
`define FPD_USER_LO_B 8'h64
`define FPD_USER_HI_B 8'h6E
`define FPD_USER_CNT_A 8
`define FPD_USER_CNT 19
`define FPD_EXC_FLAG 8'h80
`define FPD_FILE_REF_TYPE 8'h06
`define FPD_DIAG_SUB_MAX 16'h0012
`define FPD_DIAG_SUB_EXTRA 16'h0014
`define FPD_ENCAP_SUB_GEN 8'h0D
`define FPD_ENCAP_SUB_ID 8'h0E
`define FPD_EXC_ILLEGAL_FN 8'h01
`define FPD_EXC_ILLEGAL_VAL 8'h03
`define FPD_HDR_BYTES 4
`endif

// file: common/fpd_pkg.sv
// types shared by the function code decoder
package fpd_pkg;
  typedef enum logic [4:0] {
    FK_NONE, FK_RD_DISC, FK_RD_COILS, FK_WR_COIL, FK_WR_COILS,
    FK_RD_INREG, FK_RD_HOLD, FK_WR_REG, FK_WR_REGS, FK_RW_REGS,
    FK_MASK_WR, FK_RD_QUEUE, FK_RD_FILE, FK_WR_FILE, FK_RD_EXCST,
    FK_DIAG, FK_EVT_CNT, FK_EVT_LOG, FK_SRV_ID, FK_ENCAP, FK_USER
  } fpd_kind_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } fpd_byte_t;

  typedef struct packed {
    fpd_kind_t kind;
    logic [7:0] fc;
    logic [15:0] subCode;
    logic [15:0] pduAddr;
    logic [16:0] elemNum;
    logic [15:0] wordIdx;
    logic [3:0] bitPos;
    logic bitAccess;
  } fpd_cmd_t;

  typedef struct packed {
    logic error;
    logic [7:0] excCode;
  } fpd_result_t;
endpackage

// file: rtl/fpd_addr_map.sv
// maps a pdu address to its model element number and to a place in one shared word block
`timescale 1ns/1ps
`default_nettype none
module fpd_addr_map (
  input wire logic [15:0] pduAddr,
  input wire logic bitAccess,
  output logic [16:0] elemNum,
  output logic [15:0] wordIdx,
  output logic [3:0] bitPos
);
  always_comb begin
    // element numbers count from one, pdu addresses from zero
    elemNum = {1'b0, pduAddr} + 17'h0_0001;
    // bits and words overlay: sixteen bit addresses share one word
    if (bitAccess) begin
      wordIdx = {4'h0, pduAddr[15:4]};
      bitPos = pduAddr[3:0];
    end else begin
      wordIdx = pduAddr;
      bitPos = 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/fpd_decoder.sv
// request pdu function decoder and response header builder
`timescale 1ns/1ps
`default_nettype none
`include "fpd_cfg.svh"

module fpd_decoder
  import fpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire fpd_pkg::fpd_byte_t reqByte,
  output logic reqReady,
  input wire logic [`FPD_USER_CNT-1:0] userFnEnable,
  output logic cmdValid,
  output fpd_pkg::fpd_cmd_t cmd,
  input wire logic appDone,
  input wire fpd_pkg::fpd_result_t appResult,
  output logic rspValid,
  output fpd_pkg::fpd_byte_t rspByte,
  input wire logic rspReady,
  output logic excEvent
);
  import fpd_pkg::*;

  // idle takes the code byte, recv stores up to four header bytes, eval
  // decides, app waits on the application, then the code byte and, on
  // error, the exception byte go out
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_EVAL, ST_APP, ST_RSP_FC, ST_RSP_EXC
  } fpd_state_t;

  fpd_state_t state;
  fpd_state_t next_state;
  logic [7:0] fc;
  logic [7:0] next_fc;
  // only the first four bytes after the code matter to the decode
  logic [7:0] hdr [`FPD_HDR_BYTES];
  logic [7:0] next_hdr [`FPD_HDR_BYTES];
  logic [2:0] byteCnt;
  logic [2:0] next_byteCnt;
  logic isError;
  logic next_isError;
  logic [7:0] excCode;
  logic [7:0] next_excCode;
  fpd_cmd_t next_cmd;
  logic excPulse;
  logic next_excPulse;

  fpd_kind_t kind;
  logic known;
  logic subOk;
  logic bitAcc;
  logic [15:0] sub16;
  logic [15:0] addrField;
  logic [16:0] mapElem;
  logic [15:0] mapWord;
  logic [3:0] mapBit;
  logic [4:0] userIdx;
  logic userHit;

  // address fields arrive high byte first
  assign addrField = {hdr[0], hdr[1]};

  fpd_addr_map uMap (
    .pduAddr(addrField),
    .bitAccess(bitAcc),
    .elemNum(mapElem),
    .wordIdx(mapWord),
    .bitPos(mapBit)
  );

  // user ranges are checked against a per-code enable, so only codes
  // the application really implements are forwarded
  always_comb begin
    userHit = 1'b0;
    userIdx = 5'h00;
    if (fc >= `FPD_USER_LO_A && fc <= `FPD_USER_HI_A) begin
      userIdx = 5'(fc - `FPD_USER_LO_A);
      userHit = 1'b1;
    end else if (fc >= `FPD_USER_LO_B && fc <= `FPD_USER_HI_B) begin
      userIdx = 5'(fc - `FPD_USER_LO_B + 8'(`FPD_USER_CNT_A));
      userHit = 1'b1;
    end
  end

  // code classification; anything not listed and not an enabled user code,
  // vendor-reserved codes included, stays unknown and is refused
  always_comb begin
    kind = FK_NONE;
    known = 1'b1;
    subOk = 1'b1;
    bitAcc = 1'b0;
    sub16 = 16'h0000;
    case (fc)
      `FPD_FC_RD_DISC: begin
        kind = FK_RD_DISC;
        bitAcc = 1'b1;
      end
      `FPD_FC_RD_COILS: begin
        kind = FK_RD_COILS;
        bitAcc = 1'b1;
      end
      `FPD_FC_WR_COIL: begin
        kind = FK_WR_COIL;
        bitAcc = 1'b1;
      end
      `FPD_FC_WR_COILS: begin
        kind = FK_WR_COILS;
        bitAcc = 1'b1;
      end
      `FPD_FC_RD_INREG: kind = FK_RD_INREG;
      `FPD_FC_RD_HOLD: kind = FK_RD_HOLD;
      `FPD_FC_WR_REG: kind = FK_WR_REG;
      `FPD_FC_WR_REGS: kind = FK_WR_REGS;
      `FPD_FC_RW_REGS: kind = FK_RW_REGS;
      `FPD_FC_MASK_WR: kind = FK_MASK_WR;
      `FPD_FC_RD_QUEUE: kind = FK_RD_QUEUE;
      `FPD_FC_RD_FILE: begin
        kind = FK_RD_FILE;
        // reference type follows the byte count
        sub16 = {8'h00, hdr[1]};
        subOk = (hdr[1] == `FPD_FILE_REF_TYPE);
      end
      `FPD_FC_WR_FILE: begin
        kind = FK_WR_FILE;
        sub16 = {8'h00, hdr[1]};
        subOk = (hdr[1] == `FPD_FILE_REF_TYPE);
      end
      `FPD_FC_RD_EXCST: kind = FK_RD_EXCST;
      `FPD_FC_DIAG: begin
        kind = FK_DIAG;
        sub16 = {hdr[0], hdr[1]};
        subOk = (sub16 <= `FPD_DIAG_SUB_MAX) || (sub16 == `FPD_DIAG_SUB_EXTRA);
      end
      `FPD_FC_EVT_CNT: kind = FK_EVT_CNT;
      `FPD_FC_EVT_LOG: kind = FK_EVT_LOG;
      `FPD_FC_SRV_ID: kind = FK_SRV_ID;
      `FPD_FC_ENCAP: begin
        kind = FK_ENCAP;
        sub16 = {8'h00, hdr[0]};
        subOk = (hdr[0] == `FPD_ENCAP_SUB_GEN) || (hdr[0] == `FPD_ENCAP_SUB_ID);
      end
      default: begin
        // vendor-reserved codes land here too and are never claimed
        if (userHit && userFnEnable[userIdx]) begin
          kind = FK_USER;
        end else begin
          known = 1'b0;
        end
      end
    endcase
  end

  // handshakes decode straight from the state register, so they
  // never lag the state by a cycle
  assign reqReady = (state == ST_IDLE) || (state == ST_RECV);
  assign cmdValid = (state == ST_APP);
  assign rspValid = (state == ST_RSP_FC) || (state == ST_RSP_EXC);
  assign excEvent = excPulse;

  // the response byte is a pure decode of registered state
  always_comb begin
    rspByte.data = 8'h00;
    rspByte.last = 1'b0;
    if (state == ST_RSP_FC) begin
      // on error the top bit marks an exception; codes from 128 up are
      // already invalid and come back unchanged with that bit set
      rspByte.data = isError ? (fc | `FPD_EXC_FLAG) : fc;
      rspByte.last = 1'b0;
    end else if (state == ST_RSP_EXC) begin
      rspByte.data = excCode;
      rspByte.last = 1'b1;
    end
  end

  // payload past the header is left to the application; this block
  // only answers with the function code and, on error, the reason
  always_comb begin
    next_state = state;
    next_fc = fc;
    next_hdr = hdr;
    next_byteCnt = byteCnt;
    next_isError = isError;
    next_excCode = excCode;
    next_cmd = cmd;
    next_excPulse = 1'b0;
    case (state)
      ST_IDLE: begin
        if (reqValid) begin
          next_fc = reqByte.data;
          next_byteCnt = 3'd0;
          for (int i = 0; i < `FPD_HDR_BYTES; i++) begin
            next_hdr[i] = 8'h00;
          end
          next_state = reqByte.last ? ST_EVAL : ST_RECV;
        end
      end
      ST_RECV: begin
        if (reqValid) begin
          // bytes past the header are taken and dropped, so a long pdu
          // still drains and the link never stalls
          if (byteCnt < 3'(`FPD_HDR_BYTES)) begin
            next_hdr[byteCnt[1:0]] = reqByte.data;
            next_byteCnt = byteCnt + 3'd1;
          end
          if (reqByte.last) begin
            next_state = ST_EVAL;
          end
        end
      end
      ST_EVAL: begin
        // cmd is registered here and held until the next decode
        next_cmd.kind = kind;
        next_cmd.fc = fc;
        next_cmd.subCode = sub16;
        next_cmd.pduAddr = addrField;
        next_cmd.elemNum = mapElem;
        next_cmd.wordIdx = mapWord;
        next_cmd.bitPos = mapBit;
        next_cmd.bitAccess = bitAcc;
        if (!known) begin
          next_isError = 1'b1;
          next_excCode = `FPD_EXC_ILLEGAL_FN;
          next_excPulse = 1'b1;
          next_state = ST_RSP_FC;
        end else if (!subOk) begin
          next_isError = 1'b1;
          next_excCode = `FPD_EXC_ILLEGAL_VAL;
          next_excPulse = 1'b1;
          next_state = ST_RSP_FC;
        end else begin
          next_isError = 1'b0;
          next_excCode = 8'h00;
          next_state = ST_APP;
        end
      end
      ST_APP: begin
        // appDone is only looked at while the command is offered
        if (appDone) begin
          next_isError = appResult.error;
          next_excCode = appResult.excCode;
          next_excPulse = appResult.error;
          next_state = ST_RSP_FC;
        end
      end
      ST_RSP_FC: begin
        if (rspReady) begin
          // a positive answer ends here; its payload is the application's
          next_state = isError ? ST_RSP_EXC : ST_IDLE;
        end
      end
      ST_RSP_EXC: begin
        if (rspReady) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // synchronous reset; one low edge is enough to abort any transfer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      fc <= 8'h00;
      for (int i = 0; i < `FPD_HDR_BYTES; i++) begin
        hdr[i] <= 8'h00;
      end
      byteCnt <= 3'd0;
      isError <= 1'b0;
      excCode <= 8'h00;
      cmd <= '0;
      excPulse <= 1'b0;
    end else begin
      state <= next_state;
      fc <= next_fc;
      hdr <= next_hdr;
      byteCnt <= next_byteCnt;
      isError <= next_isError;
      excCode <= next_excCode;
      cmd <= next_cmd;
      excPulse <= next_excPulse;
    end
  end
endmodule
`default_nettype wire

// file: sim/fpd_decoder_properties.sv
// port checks for the function code decoder
`timescale 1ns/1ps
`default_nettype none
module fpd_decoder_props
  import fpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire fpd_pkg::fpd_byte_t reqByte,
  input wire logic reqReady,
  input wire logic cmdValid,
  input wire fpd_pkg::fpd_cmd_t cmd,
  input wire logic appDone,
  input wire fpd_pkg::fpd_result_t appResult,
  input wire logic rspValid,
  input wire fpd_pkg::fpd_byte_t rspByte,
  input wire logic rspReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence lastTaken;
    reqValid && reqReady && reqByte.last;
  endsequence
  sequence appOk;
    cmdValid && appDone && !appResult.error;
  endsequence
  sequence appBad;
    cmdValid && appDone && appResult.error;
  endsequence
  sequence excHead;
    rspValid && rspReady && !rspByte.last && rspByte.data[7];
  endsequence
  a_eval_two_edges: assert property (lastTaken |=> !reqReady ##1 (cmdValid || rspValid))
    else $error("no command or refusal two edges after the last byte");
  a_pos_echo: assert property (appOk |=> rspValid && !rspByte.last && rspByte.data == $past(cmd.fc))
    else $error("positive response does not echo the code");
  a_exc_head: assert property (appBad |=> rspValid && rspByte.data == ($past(cmd.fc) | 8'h80))
    else $error("exception response lacks the flag");
  a_exc_tail: assert property (excHead |=> rspValid && rspByte.last)
    else $error("exception code byte missing");
  a_elem_plus: assert property (cmdValid |-> cmd.elemNum == {1'b0, cmd.pduAddr} + 17'h0_0001)
    else $error("element number is not address plus one");
  a_bit_overlay: assert property (cmdValid && cmd.bitAccess |->
    cmd.wordIdx == {4'h0, cmd.pduAddr[15:4]} && cmd.bitPos == cmd.pduAddr[3:0])
    else $error("bit overlay position wrong");
  a_bit_codes: assert property (cmdValid && cmd.bitAccess |->
    cmd.fc inside {8'h01, 8'h02, 8'h05, 8'h0F})
    else $error("bit access for a word code");
  a_user_range: assert property (cmdValid && cmd.kind == FK_USER |->
    cmd.fc inside {[8'h41:8'h48], [8'h64:8'h6E]})
    else $error("user kind outside the user ranges");
  a_word_kind: assert property (cmdValid && cmd.fc == 8'h03 |-> cmd.kind == FK_RD_HOLD)
    else $error("holding read decoded wrong");
endmodule
`default_nettype wire

// file: sim/fpd_client.sv
// remote client model: issues request pdus and sinks response bytes
`timescale 1ns/1ps
`default_nettype none
module fpd_client
  import fpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reqReady,
  output logic reqValid,
  output fpd_pkg::fpd_byte_t reqByte,
  output logic rspReady
);
  logic slow = 1'b0;
  logic [1:0] stall = 2'h0;
  initial begin
    reqValid = 1'b0;
    reqByte = '0;
  end
  always @(posedge ref_clk) stall <= #2 stall + 2'h1;
  // a slow sink takes one byte in four
  assign rspReady = !slow || stall == 2'h3;
  // b1,b2 carry the element number minus one, high byte first
  task automatic send(input logic [7:0] fc, b1, b2);
    logic [7:0] pdu [5];
    pdu = '{fc, b1, b2, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      reqValid = 1'b1;
      reqByte = '{data: pdu[i], last: i == 4};
      @(negedge ref_clk);
      while (!reqReady) @(negedge ref_clk);
      @(posedge ref_clk);
      #2;
    end
    reqValid = 1'b0;
    // released line shows no stale value
    reqByte.data = ~pdu[4];
  endtask
endmodule
`default_nettype wire

// file: sim/fpd_decoder_tb.sv
// bench for the function decoder: public, user, refused and failed requests
`timescale 1ns/1ps
`default_nettype none
module fpd_decoder_tb;
  import fpd_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic appDone = 1'b0;
  logic reqValid, reqReady, cmdValid, rspValid, rspReady, excEvent;
  logic [18:0] userFnEnable = 19'h7_FFFF;
  fpd_byte_t reqByte, rspByte;
  fpd_cmd_t cmd;
  fpd_result_t appResult = '0;
  int fails = 0, testsRun = 0, cyc = 0, excCnt = 0;
  initial forever #25 ref_clk = ~ref_clk;
  fpd_decoder fpd_decoder_i (.ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid),
    .reqByte(reqByte), .reqReady(reqReady), .userFnEnable(userFnEnable),
    .cmdValid(cmdValid), .cmd(cmd), .appDone(appDone), .appResult(appResult),
    .rspValid(rspValid), .rspByte(rspByte), .rspReady(rspReady), .excEvent(excEvent));
  fpd_client fpd_client_i (.ref_clk(ref_clk), .reqReady(reqReady), .reqValid(reqValid),
    .reqByte(reqByte), .rspReady(rspReady));
  always @(posedge ref_clk) if (excEvent === 1'b1) excCnt++;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic getRsp(output fpd_byte_t b);
    int n = 0;
    @(negedge ref_clk);
    while (!(rspValid && rspReady) && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
    b = rspByte;
    @(posedge ref_clk);
    #2;
  endtask
  // e0/e1: expected response bytes; bad makes the application report e1
  task automatic xact(input logic [7:0] fc, b1, b2, e0, e1, input logic bad);
    fpd_byte_t r;
    int n = 0;
    int base = excCnt;
    fpd_client_i.send(fc, b1, b2);
    if (bad || (e0 == fc && !fc[7])) begin
      while (cmdValid !== 1'b1 && n < 20) begin
        n++;
        @(posedge ref_clk);
        #2;
      end
      chk("cmd fc", {9'h0, fc}, cmd.fc);
      chk("elem", {1'b0, b1, b2} + 17'h0_0001, cmd.elemNum);
      appDone = 1'b1;
      appResult = '{error: bad, excCode: e1};
      @(posedge ref_clk);
      #2;
      appDone = 1'b0;
    end
    getRsp(r);
    chk("rsp head", {e0, 1'b0}, r);
    if (e0[7]) begin
      getRsp(r);
      chk("rsp code", {e1, 1'b1}, r);
    end
    chk("exc event", {16'h0000, e0[7]}, 17'(excCnt - base));
    chk("ready", 1'b1, reqReady);
  endtask
  task automatic t_public();
    logic [7:0] c [19];
    c = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0B, 8'h0C,
      8'h0F, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h2B};
    foreach (c[i]) xact(c[i], c[i] == 8'h2B ? 8'h0E : 8'h00,
      c[i] inside {8'h14, 8'h15} ? 8'h06 : 8'h12, c[i], 8'h00, 1'b0);
  endtask
  task automatic t_user();
    userFnEnable = 19'h7_FEFE;
    xact(8'h48, 8'h00, 8'h00, 8'h48, 8'h00, 1'b0);
    xact(8'h6E, 8'h00, 8'h00, 8'h6E, 8'h00, 1'b0);
    xact(8'h41, 8'h00, 8'h00, 8'hC1, 8'h01, 1'b0);
    xact(8'h64, 8'h00, 8'h00, 8'hE4, 8'h01, 1'b0);
    xact(8'h40, 8'h00, 8'h00, 8'hC0, 8'h01, 1'b0);
    xact(8'h6F, 8'h00, 8'h00, 8'hEF, 8'h01, 1'b0);
    userFnEnable = 19'h7_FFFF;
  endtask
  task automatic t_refuse();
    xact(8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 1'b0);
    xact(8'h09, 8'h00, 8'h00, 8'h89, 8'h01, 1'b0);
    xact(8'h85, 8'h00, 8'h00, 8'h85, 8'h01, 1'b0);
    xact(8'hFF, 8'h00, 8'h00, 8'hFF, 8'h01, 1'b0);
  endtask
  task automatic t_subcode();
    xact(8'h08, 8'h00, 8'h13, 8'h88, 8'h03, 1'b0);
    xact(8'h08, 8'h00, 8'h14, 8'h08, 8'h00, 1'b0);
    chk("sub code", 17'h0_0014, {1'b0, cmd.subCode});
    xact(8'h08, 8'h00, 8'h15, 8'h88, 8'h03, 1'b0);
    xact(8'h2B, 8'h0C, 8'h00, 8'hAB, 8'h03, 1'b0);
    xact(8'h2B, 8'h0D, 8'h00, 8'h2B, 8'h00, 1'b0);
    xact(8'h14, 8'h00, 8'h05, 8'h94, 8'h03, 1'b0);
    xact(8'h15, 8'h00, 8'h07, 8'h95, 8'h03, 1'b0);
  endtask
  task automatic t_app_err();
    fpd_client_i.slow = 1'b1;
    xact(8'h03, 8'hFF, 8'hFF, 8'h83, 8'h04, 1'b1);
    xact(8'h01, 8'h12, 8'h34, 8'h01, 8'h00, 1'b0);
    chk("kind", {12'h000, FK_RD_COILS}, {12'h000, cmd.kind});
    chk("word idx", 17'h0_0123, {1'b0, cmd.wordIdx});
    chk("bit pos", 17'h0_0004, {13'h0000, cmd.bitPos});
    xact(8'h06, 8'hFF, 8'hFF, 8'h06, 8'h00, 1'b0);
    chk("pdu addr", 17'h0_FFFF, {1'b0, cmd.pduAddr});
    chk("word idx", 17'h0_FFFF, {1'b0, cmd.wordIdx});
    chk("bit access", 17'h0_0000, {16'h0000, cmd.bitAccess});
    fpd_client_i.slow = 1'b0;
  endtask
  // reset lands while the decode is pending; the command must never appear
  task automatic t_reset();
    fpd_client_i.send(8'h03, 8'h00, 8'h13);
    rstn = 1'b0;
    @(posedge ref_clk);
    #2;
    chk("rst rsp", 17'h0_0000, {16'h0000, rspValid});
    chk("rst cmd", 17'h0_0000, {16'h0000, cmdValid});
    chk("rst ready", 17'h0_0001, {16'h0000, reqReady});
    rstn = 1'b1;
    xact(8'h03, 8'h00, 8'h13, 8'h03, 8'h00, 1'b0);
  endtask
  task automatic conclude();
    $display("fails=%0d testsRun=%0d", fails, testsRun);
    if (fails == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    t_public();
    t_user();
    t_refuse();
    t_subcode();
    t_app_err();
    t_reset();
    conclude();
  end
endmodule
bind fpd_decoder fpd_decoder_props fpd_decoder_props_i (.ref_clk(ref_clk), .rstn(rstn),
  .reqValid(reqValid), .reqByte(reqByte), .reqReady(reqReady), .cmdValid(cmdValid),
  .cmd(cmd), .appDone(appDone), .appResult(appResult), .rspValid(rspValid),
  .rspByte(rspByte), .rspReady(rspReady));
`default_nettype wire
